// file: dv/low_voltage_detect_ctrl_chk.sv
`timescale 1ns/1ps
module low_voltage_detect_ctrl_chk
  import lvd_ctrl_pkg::*;
(
  // clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic detector_reset_n,
  // register port and analog side
  input wire lvd_ctrl_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  input wire lvd_ctrl_pkg::comparator_t cmp,
  input wire logic below_reset_threshold,
  input wire lvd_ctrl_pkg::analog_ctl_t ctl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a lone write shows on its control output two edges later
  property p_fld(a, b, o);
    req.write && req.addr == a ##1 !(req.write && req.addr == a) |=> o == $past(req.wdata[b], 2);
  endproperty
  chk_enable_out: assert property (p_fld(ADDR_CONTROL, CTL_ENABLE, ctl.detector_enable)) else $error("enable");
  chk_drop_src: assert property (p_fld(ADDR_CONTROL, CTL_DROP_SRC, ctl.drop_level_source_select)) else $error("drop src");
  chk_rise_src: assert property (p_fld(ADDR_CONTROL, CTL_RISE_SRC, ctl.rise_level_source_select)) else $error("rise src");
  chk_thresh_sel: assert property (p_fld(ADDR_CONTROL, CTL_RST_SEL, ctl.reset_threshold_select)) else $error("thresh");
  chk_ref_src: assert property (p_fld(ADDR_STATUS, STS_REF_SRC, ctl.reference_source_select)) else $error("ref src");
  chk_zero_bit: assert property (req.read && req.addr == ADDR_STATUS |=> !rdata[STS_ZERO]) else $error("bit2");
  chk_reset_gate: assert property (!below_reset_threshold [*6] |=> !ctl.undervoltage_reset_request) else $error("rst");
  chk_rdata_idle: assert property (!req.read |=> rdata == 8'h00) else $error("rdata idle");
  chk_unmapped_zero: assert property (req.read && req.addr == 2'h3 |=> rdata == 8'h00) else $error("unmapped");
  cover property (ctl.drop_irq && ctl.rise_irq);
  cover property (ctl.undervoltage_reset_request);
  cover property (req.read && req.addr == ADDR_COUNTER);
endmodule
bind low_voltage_detect_ctrl low_voltage_detect_ctrl_chk u_low_voltage_detect_ctrl_chk(.*);

// file: dv/lvd_analog_model.sv
`timescale 1ns/1ps
module lvd_analog_model
  import lvd_ctrl_pkg::*;
(
  // test commands
  input wire logic drop_on,
  input wire logic rise_on,
  input wire logic below_on,
  // block side
  input wire lvd_ctrl_pkg::analog_ctl_t ctl,
  output lvd_ctrl_pkg::comparator_t cmp,
  output logic below_reset_threshold,
  output logic detector_reset_n
);
  assign cmp = '{supply_drop_detect: drop_on & ctl.detector_enable, supply_rise_detect: rise_on & ctl.detector_enable};
  assign below_reset_threshold = below_on;
  // reset loop back
  // the request holds the block in detector reset for as long as the supply stays low
  assign detector_reset_n = ~(ctl.undervoltage_reset_request === 1'b1);
endmodule

// file: dv/tb_low_voltage_detect_ctrl.sv
`timescale 1ns/1ps
module tb_low_voltage_detect_ctrl;
  import lvd_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic drop_on = 1'b0;
  logic rise_on = 1'b0;
  logic below_on = 1'b0;
  logic detector_reset_n;
  logic below_reset_threshold;
  logic [7:0] rdata;
  reg_req_t req = '0;
  comparator_t cmp;
  analog_ctl_t ctl;
  int miscompares = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  low_voltage_detect_ctrl u_low_voltage_detect_ctrl(.*);
  lvd_analog_model u_lvd_analog_model(.*);
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clk);
    req.write <= 1'b0;
  endtask
  task automatic rd(logic [1:0] a, logic [7:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge clk);
    req.read <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic wait_clk(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 4; a++) rd(2'(a), 8'h00);
    wr(ADDR_CONTROL, 8'h7F);
    rd(ADDR_CONTROL, 8'h7F);
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, 8'h78);
    chk({7'h00, ctl.reference_source_select}, 8'h01);
    wr(ADDR_CONTROL, 8'hF7);
    drop_on <= 1'b1;
    rise_on <= 1'b1;
    wait_clk(8);
    chk({5'h00, ctl.detector_enable, ctl.drop_level_source_select, ctl.rise_level_source_select}, 8'h07);
    chk({6'h00, ctl.drop_irq, ctl.rise_irq}, 8'h03);
    drop_on <= 1'b0;
    rise_on <= 1'b0;
    // flags survive a zero write until a read has seen them set
    wr(ADDR_STATUS, 8'h78);
    rd(ADDR_STATUS, 8'h7B);
    wr(ADDR_STATUS, 8'h78);
    rd(ADDR_STATUS, 8'h78);
    chk({6'h00, ctl.drop_irq, ctl.rise_irq}, 8'h00);
    wait_clk(1040);
    rd(ADDR_STATUS, 8'hF8);
    rd(ADDR_COUNTER, 8'h00);
    below_on <= 1'b1;
    wait_clk(8);
    chk({7'h00, ctl.undervoltage_reset_request}, 8'h01);
    below_on <= 1'b0;
    wait_clk(12);
    rd(ADDR_CONTROL, 8'h84);
    rd(ADDR_STATUS, 8'h78);
    wr(ADDR_CONTROL, 8'h8C);
    rd(ADDR_CONTROL, 8'h8C);
    chk({7'h00, ctl.reset_threshold_select}, 8'h01);
    wr(ADDR_COUNTER, 8'h5A);
    rd(ADDR_COUNTER, 8'h00);
    drop_on <= 1'b1;
    rise_on <= 1'b1;
    wait_clk(8);
    chk({6'h00, ctl.drop_irq, ctl.rise_irq}, 8'h00);
    rd(ADDR_STATUS, 8'h7B);
    drop_on <= 1'b0;
    rise_on <= 1'b0;
    rst_n <= 1'b0;
    wait_clk(2);
    rst_n <= 1'b1;
    rd(ADDR_CONTROL, 8'h00);
    final_report();
  end
  initial begin
    #60us;
    miscompares++;
    final_report();
  end
endmodule

// file: hdl/low_voltage_detect_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - control bit 7 enables the detector; zero holds it in standby
// - enable, threshold select, reset enable survive detector reset; cleared by power-on/watchdog
// - control bit 5 picks drop threshold: ladder or external drop pin
// - control bit 4 picks rise threshold: ladder or external rise pin
// - control bit 3 picks reset threshold: low level at 0, high at 1
// - control bit 2 gates the undervoltage reset when supply falls below threshold
// - control bit 1 gates the supply-drop interrupt request
// - control bit 0 gates the supply-rise interrupt request
// - control bit 6 is a plain read/write reserved bit
// - detector reset clears stable, drop and rise status flags
// - status bit 7 sets when the settling counter overflows
// - status flags clear from software only by writing 0 after reading 1
// - status bit 3 picks reference: on-chip generator or external pin
// - status bit 2 reads zero and ignores writes
// - status bits 6 to 4 are plain read/write reserved bits
// - status bit 1 sets when supply falls below drop threshold
// - status bit 0 sets when a supply rise is detected
// - 8-bit read-only counter starts on enable, counts at clock/4, rolls FF to 00 and stops there
module low_voltage_detect_ctrl
  import lvd_ctrl_pkg::*;
(
  // clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic detector_reset_n,
  // register port
  input wire lvd_ctrl_pkg::reg_req_t req,
  output logic [7:0] rdata,
  // analog comparators
  input wire lvd_ctrl_pkg::comparator_t cmp,
  input wire logic below_reset_threshold,
  // analog controls and requests
  output lvd_ctrl_pkg::analog_ctl_t ctl
);
  import lvd_ctrl_pkg::*;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] status;
    logic [7:0] counter;
    logic [1:0] prescale;
    logic counting;
    logic [7:0] read_one;
    logic [1:0] drop_sync;
    logic [1:0] rise_sync;
    logic [1:0] below_sync;
    logic [1:0] det_sync;
    logic [7:0] rdata;
    analog_ctl_t ctl;
  } state_t;

  state_t s;
  state_t next_s;

  function automatic logic [7:0] read_mux(input logic [1:0] a, input state_t st);
    if (a == ADDR_CONTROL) begin
      return st.control;
    end else if (a == ADDR_STATUS) begin
      return st.status;
    end else if (a == ADDR_COUNTER) begin
      return st.counter;
    end else begin
      return 8'h00;
    end
  endfunction

  // write strobe aimed at one register index
  function automatic logic write_to(input reg_req_t r, input logic [1:0] a);
    return r.write && (r.addr == a);
  endfunction

  // read strobe aimed at one register index
  function automatic logic read_of(input reg_req_t r, input logic [1:0] a);
    return r.read && (r.addr == a);
  endfunction

  // two-stage synchroniser shift; logic may only look at bit 1
  function automatic logic [1:0] sync_shift(input logic [1:0] prev, input logic pin);
    return {prev[0], pin};
  endfunction

  // arm the flags that a status read has just seen as one
  function automatic logic [7:0] arm_flags(input logic [7:0] armed, input logic [7:0] status);
    return armed | (status & STS_FLAG_MASK);
  endfunction

  // a zero write clears only flags that a read has armed
  function automatic logic [7:0] clear_flags(input logic [7:0] status, input logic [7:0] armed, input logic [7:0] wdata);
    return status & ~(STS_FLAG_MASK & armed & ~wdata);
  endfunction

  // a zero write spends the arm mark, a one write keeps it
  function automatic logic [7:0] disarm_flags(input logic [7:0] armed, input logic [7:0] wdata);
    return armed & ~(STS_FLAG_MASK & ~wdata);
  endfunction

  // merge the plain status bits from a write; flags are untouched here
  function automatic logic [7:0] merge_plain(input logic [7:0] status, input logic [7:0] wdata);
    return (status & ~STS_PLAIN_MASK) | (wdata & STS_PLAIN_MASK);
  endfunction

  // enable written from zero to one starts a fresh settling count
  function automatic logic enable_rising(input reg_req_t r, input logic [7:0] control);
    return write_to(r, ADDR_CONTROL) && r.wdata[CTL_ENABLE] && !control[CTL_ENABLE];
  endfunction

  // the prescaler is on its last phase, so the counter steps now
  function automatic logic count_tick(input state_t st);
    return st.counting && (st.prescale == PRESCALE_LAST);
  endfunction

  // state after a detector-triggered reset
  function automatic state_t detector_reset_state(input state_t cur, input state_t nxt);
    state_t r;
    r = nxt;
    // status keeps reference select and reserved bits only
    r.status = cur.status & ~STS_DET_CLR_MASK;
    r.read_one = 8'h00;
    // enable, threshold select and reset enable survive
    r.control = cur.control & CTL_KEEP_MASK;
    // the reference must settle again, so the count is dropped
    r.counter = CNT_RESET;
    r.prescale = PRESCALE_START;
    r.counting = 1'b0;
    r.rdata = 8'h00;
    return r;
  endfunction

  // control outputs as levels taken from registered state
  function automatic analog_ctl_t drive_ctl(input state_t st);
    analog_ctl_t c;
    c = '0;
    c.detector_enable = st.control[CTL_ENABLE];
    c.drop_level_source_select = st.control[CTL_DROP_SRC];
    c.rise_level_source_select = st.control[CTL_RISE_SRC];
    c.reset_threshold_select = st.control[CTL_RST_SEL];
    c.reference_source_select = st.status[STS_REF_SRC];
    c.undervoltage_reset_request = st.control[CTL_ENABLE] & st.control[CTL_RST_EN] & st.below_sync[1];
    c.drop_irq = st.control[CTL_DROP_IE] & st.status[STS_DROP];
    c.rise_irq = st.control[CTL_RISE_IE] & st.status[STS_RISE];
    return c;
  endfunction

  always_comb begin
    next_s = s;

    // analog and reset-pin levels come from outside the clock domain
    next_s.drop_sync = sync_shift(s.drop_sync, cmp.supply_drop_detect);
    next_s.rise_sync = sync_shift(s.rise_sync, cmp.supply_rise_detect);
    next_s.below_sync = sync_shift(s.below_sync, below_reset_threshold);
    next_s.det_sync = sync_shift(s.det_sync, detector_reset_n);

    // read data stands for one cycle only and is zero otherwise
    next_s.rdata = 8'h00;
    if (req.read) begin
      next_s.rdata = read_mux(req.addr, s);
    end
    if (read_of(req, ADDR_STATUS)) begin
      next_s.read_one = arm_flags(s.read_one, s.status);
    end

    if (write_to(req, ADDR_CONTROL)) begin
      next_s.control = req.wdata;
    end
    if (enable_rising(req, s.control)) begin
      next_s.counting = 1'b1;
      next_s.counter = CNT_RESET;
      next_s.prescale = PRESCALE_START;
    end
    // clearing the enable abandons the settling count
    if (write_to(req, ADDR_CONTROL) && !req.wdata[CTL_ENABLE]) begin
      next_s.counting = 1'b0;
    end

    if (write_to(req, ADDR_STATUS)) begin
      next_s.status = merge_plain(s.status, req.wdata);
      // clear only after a read of one
      next_s.status = clear_flags(next_s.status, s.read_one, req.wdata);
      next_s.read_one = disarm_flags(s.read_one, req.wdata);
    end
    // writes to the counter index and to index 3 are dropped on purpose

    if (s.counting) begin
      next_s.prescale = s.prescale + PRESCALE_STEP;
    end
    if (count_tick(s)) begin
      next_s.counter = s.counter + CNT_STEP;
    end
    // stable flag on overflow; counting stops there
    if (count_tick(s) && (s.counter == CNT_MAX)) begin
      next_s.status[STS_STABLE] = 1'b1;
      next_s.counting = 1'b0;
    end

    // hardware sets come after the software clear so that a set wins
    // drop and rise detection
    if (s.control[CTL_ENABLE] && s.drop_sync[1]) begin
      next_s.status[STS_DROP] = 1'b1;
    end
    if (s.control[CTL_ENABLE] && s.rise_sync[1]) begin
      next_s.status[STS_RISE] = 1'b1;
    end
    next_s.status[STS_ZERO] = 1'b0;

    // detector reset clears flags, keeps chosen control bits
    if (!s.det_sync[1]) begin
      next_s = detector_reset_state(s, next_s);
    end

    next_s.ctl = drive_ctl(s);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // power-on or watchdog reset clears everything except the detector-reset synchroniser, which starts at 11
      s <= '0;
      s.control <= CTL_RESET;
      s.status <= STS_RESET;
      s.det_sync <= 2'b11;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign ctl = s.ctl;

endmodule

// file: hdl/lvd_ctrl_pkg.sv
package lvd_ctrl_pkg;

  // register indices on the plain register port
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_COUNTER = 2'h2;

  // control field positions
  localparam int CTL_ENABLE = 7;
  localparam int CTL_DROP_SRC = 5;
  localparam int CTL_RISE_SRC = 4;
  localparam int CTL_RST_SEL = 3;
  localparam int CTL_RST_EN = 2;
  localparam int CTL_DROP_IE = 1;
  localparam int CTL_RISE_IE = 0;

  // status field positions
  localparam int STS_STABLE = 7;
  localparam int STS_REF_SRC = 3;
  localparam int STS_ZERO = 2;
  localparam int STS_DROP = 1;
  localparam int STS_RISE = 0;

  // control bits kept through a detector reset: enable, threshold select, reset enable
  localparam logic [7:0] CTL_KEEP_MASK = 8'h8C;
  // status bits cleared by a detector reset: stable, drop, rise
  localparam logic [7:0] STS_DET_CLR_MASK = 8'h83;
  // status bits that software can write directly (reserved bits and reference select)
  localparam logic [7:0] STS_PLAIN_MASK = 8'h78;
  localparam logic [7:0] STS_FLAG_MASK = 8'h83;

  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] STS_RESET = 8'h00;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [1:0] PRESCALE_START = 2'h0;
  localparam logic [1:0] PRESCALE_STEP = 2'h1;
  localparam logic [7:0] CNT_STEP = 8'h01;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } reg_req_t;

  typedef struct packed {
    logic supply_drop_detect;
    logic supply_rise_detect;
  } comparator_t;

  typedef struct packed {
    logic detector_enable;
    logic drop_level_source_select;
    logic rise_level_source_select;
    logic reset_threshold_select;
    logic reference_source_select;
    logic undervoltage_reset_request;
    logic drop_irq;
    logic rise_irq;
  } analog_ctl_t;

endpackage
